// *** hdl/rsw_defines.svh ***
// offsets, field positions, reset values and timing counts of the reset/watchdog block
// assumes it is included by the package user and the top module by its bare name
`ifndef RSW_DEFINES_SVH
`define RSW_DEFINES_SVH

`define RSW_OFF_STATUS     12'h000
`define RSW_OFF_WDCTL      12'h004
`define RSW_BOD_OFF        2'b11
`define RSW_FLAG_RST       5'h01
`define RSW_FLAG_POR       0
`define RSW_FLAG_PIN       1
`define RSW_FLAG_BOR       2
`define RSW_FLAG_WDT       3
`define RSW_FLAG_DBG       4
`define RSW_WD_BASE_LOG2   14
`define RSW_CE_LAST        3'h3
`define RSW_WDPS_RST       3'h0
`define RSW_ZERO32         32'h0000_0000

`endif

// *** hdl/rsw_pkg.sv ***
// types shared by the reset-source and watchdog block
// assumes nothing beyond the defines header
package rsw_pkg;

   typedef struct packed {
      logic [11:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } rsw_apb_req_t;

   typedef struct packed {
      logic       brownoutLevelFuse1;
      logic       brownoutLevelFuse0;
      logic       watchdogLockFuse;
   } rsw_fuse_t;

   typedef struct packed {
      logic [2:0] rsvd;
      logic       watchdogChangeEnable;
      logic       watchdogEnableBit;
      logic [2:0] watchdogPrescaleField;
   } rsw_wdctl_t;

   typedef enum logic [2:0] {
      RSW_ST_HOLD  = 3'b001,
      RSW_ST_DELAY = 3'b010,
      RSW_ST_RUN   = 3'b100
   } rsw_state_t;

endpackage

// *** hdl/rsw_top.sv ***
// reset-source logic, start-up delay, reset-cause flags and watchdog with APB registers
// assumes pins, fuses and the watchdog oscillator level are synchronous to clk
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "rsw_defines.svh"

module rsw_top #(
   parameter int WD_BASE_LOG2 = `RSW_WD_BASE_LOG2   // log2 of shortest watchdog period
) (
   input  wire logic                  clk,               // system clock, 10 MHz
   input  wire logic                  rst,               // power-on reset, async, high
   input  wire logic                  resetPinN,         // external reset pin, low active
   input  wire logic                  supplyLow,         // brown-out comparator output
   input  wire logic                  debugResetReg,     // debug scan reset register bit
   input  wire rsw_pkg::rsw_fuse_t    fuses,             // brown-out level and lock fuses
   input  wire logic [15:0]           startupDelayCycles,// start-up delay from clock fuses
   input  wire logic                  compRefSelect,     // comparator reference select
   input  wire logic                  adcEnable,         // converter enabled
   input  wire logic                  wdOscClk,          // watchdog oscillator level
   input  wire logic                  wdRestart,         // watchdog restart instruction
   input  wire rsw_pkg::rsw_apb_req_t apbReq,            // APB request
   output logic [31:0]                prdata,            // APB read data
   output logic                       pready,            // APB ready
   output logic                       pslverr,           // APB error, unmapped address
   output logic                       coreReset,         // internal reset to the core
   output logic                       refEnable          // internal reference enable
);
   import rsw_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // reset sources

   logic       bodEnabled;
   logic       bodHit;
   logic       srcSync;
   logic       asyncSet;
   logic       wdPulse_q;
   logic       wdPulse_d;
   rsw_state_t state_q;
   rsw_state_t state_d;
   logic       coreReset_q;
   logic       coreReset_d;
   logic [15:0] dlyCnt_q;
   logic [15:0] dlyCnt_d;

   assign bodEnabled = ({fuses.brownoutLevelFuse1, fuses.brownoutLevelFuse0}
                        != `RSW_BOD_OFF);
   assign bodHit     = bodEnabled & supplyLow;
   assign srcSync    = ~resetPinN | bodHit | debugResetReg | wdPulse_q;
   // pin and brown-out act without a clock edge; the reset tree is expected
   // to tolerate the glitch risk of this combined asynchronous source
   assign asyncSet   = rst | ~resetPinN | bodHit;

   always_comb begin
      state_d  = state_q;
      dlyCnt_d = dlyCnt_q;
      case (state_q)
         RSW_ST_HOLD: begin
            dlyCnt_d = 16'h0000;
            if (!srcSync) begin
               state_d = RSW_ST_DELAY;
            end
         end
         RSW_ST_DELAY: begin
            if (srcSync) begin
               state_d  = RSW_ST_HOLD;
               dlyCnt_d = 16'h0000;
            end else if (dlyCnt_q >= startupDelayCycles) begin
               state_d = RSW_ST_RUN;
            end else begin
               dlyCnt_d = dlyCnt_q + 16'h0001;
            end
         end
         RSW_ST_RUN: begin
            if (srcSync) begin
               state_d  = RSW_ST_HOLD;
               dlyCnt_d = 16'h0000;
            end
         end
         default: begin
            state_d  = RSW_ST_HOLD;
            dlyCnt_d = 16'h0000;
         end
      endcase
      coreReset_d = (state_d != RSW_ST_RUN);
   end

   always_ff @(posedge clk or posedge asyncSet) begin
      if (asyncSet) begin
         state_q     <= RSW_ST_HOLD;
         coreReset_q <= 1'b1;
         dlyCnt_q    <= 16'h0000;
      end else begin
         state_q     <= state_d;
         coreReset_q <= coreReset_d;
         dlyCnt_q    <= dlyCnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB slave, one wait state so that read data comes from a flop

   logic        access;
   logic        complete;
   logic        selStat;
   logic        selCtl;
   logic        mapped;
   logic        statWr;
   logic        ctlWr;
   logic [31:0] rdData;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic [4:0]  flags_q;
   logic [4:0]  flagSet;
   rsw_wdctl_t  ctlRead;
   rsw_wdctl_t  wrCtl;

   assign access   = apbReq.psel & apbReq.penable;
   assign complete = access & pready_q;
   assign selStat  = (apbReq.paddr == `RSW_OFF_STATUS);
   assign selCtl   = (apbReq.paddr == `RSW_OFF_WDCTL);
   assign mapped   = selStat | selCtl;
   assign statWr   = complete & apbReq.pwrite & selStat;
   assign ctlWr    = complete & apbReq.pwrite & selCtl;
   assign wrCtl    = rsw_wdctl_t'(apbReq.pwdata[7:0]);
   assign rdData   = selStat ? {27'h000_0000, flags_q} :
                     selCtl  ? {24'h00_0000, ctlRead} : `RSW_ZERO32;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= `RSW_ZERO32;
      end else begin
         pready_q  <= access & ~pready_q;
         pslverr_q <= access & ~pready_q & ~mapped;
         if (access && !pready_q) begin
            prdata_q <= rdData;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // reset-cause flags; a set in the same cycle as a software clear wins

   assign flagSet[`RSW_FLAG_POR] = 1'b0;
   assign flagSet[`RSW_FLAG_PIN] = ~resetPinN;
   assign flagSet[`RSW_FLAG_BOR] = bodHit;
   assign flagSet[`RSW_FLAG_WDT] = wdPulse_q;
   assign flagSet[`RSW_FLAG_DBG] = debugResetReg;

   for (genvar i = 0; i < 5; i++) begin : gFlag
      localparam logic [4:0] FlagRst = `RSW_FLAG_RST;
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            flags_q[i] <= FlagRst[i];
         end else if (flagSet[i]) begin
            flags_q[i] <= 1'b1;
         end else if (statWr && !apbReq.pwdata[i]) begin
            flags_q[i] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog control with timed change window

   logic       watchdog_change_enable_q;
   logic       watchdog_change_enable_d;
   logic       wdEn_q;
   logic       wdEn_d;
   logic [2:0] wdPs_q;
   logic [2:0] wdPs_d;
   logic [2:0] ceCnt_q;
   logic [2:0] ceCnt_d;
   logic       openReq;
   logic       lock;

   assign lock    = fuses.watchdogLockFuse;
   assign openReq = ctlWr & wrCtl.watchdogChangeEnable & wrCtl.watchdogEnableBit;
   assign ctlRead = '{rsvd: 3'h0,
                      watchdogChangeEnable: watchdog_change_enable_q,
                      watchdogEnableBit: wdEn_q | lock,
                      watchdogPrescaleField: wdPs_q};

   always_comb begin
      wdEn_d  = wdEn_q;
      wdPs_d  = wdPs_q;
      watchdog_change_enable_d  = watchdog_change_enable_q;
      ceCnt_d = 3'h0;
      if (coreReset_q) begin
         wdEn_d = lock;
         wdPs_d = `RSW_WDPS_RST;
         watchdog_change_enable_d = 1'b0;
      end else begin
         if (lock) begin
            wdEn_d = 1'b1;
         end else if (ctlWr && watchdog_change_enable_q) begin
            wdEn_d = wrCtl.watchdogEnableBit;
         end else if (ctlWr) begin
            wdEn_d = wdEn_q | wrCtl.watchdogEnableBit;
         end
         if (ctlWr && watchdog_change_enable_q) begin
            wdPs_d = wrCtl.watchdogPrescaleField;
         end
         if (openReq) begin
            watchdog_change_enable_d = 1'b1;
         end else if (ctlWr && watchdog_change_enable_q) begin
            watchdog_change_enable_d = 1'b0;
         end else if (watchdog_change_enable_q && ceCnt_q == `RSW_CE_LAST) begin
            watchdog_change_enable_d = 1'b0;
         end
         if (!openReq && watchdog_change_enable_q) begin
            ceCnt_d = ceCnt_q + 3'h1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wdEn_q  <= 1'b0;
         wdPs_q  <= `RSW_WDPS_RST;
         watchdog_change_enable_q  <= 1'b0;
         ceCnt_q <= 3'h0;
      end else begin
         wdEn_q  <= wdEn_d;
         wdPs_q  <= wdPs_d;
         watchdog_change_enable_q  <= watchdog_change_enable_d;
         ceCnt_q <= ceCnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog counter on the oscillator's rising edges

   logic        wdOscPrev_q;
   logic        wdTick;
   logic [21:0] wdCnt_q;
   logic [21:0] wdCnt_d;
   logic [21:0] wdLast;
   logic        wdHit;

   assign wdTick = wdOscClk & ~wdOscPrev_q;
   assign wdLast = 22'((23'h00_0001 << (WD_BASE_LOG2 + int'(wdPs_q))) - 23'h00_0001);
   assign wdHit  = (wdCnt_q == wdLast);

   always_comb begin
      wdCnt_d   = wdCnt_q;
      wdPulse_d = 1'b0;
      if (wdRestart || !wdEn_q || coreReset_q) begin
         wdCnt_d = 22'h00_0000;
      end else if (wdTick) begin
         wdCnt_d   = wdHit ? 22'h00_0000 : wdCnt_q + 22'h00_0001;
         wdPulse_d = wdHit;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wdOscPrev_q <= 1'b0;
         wdCnt_q     <= 22'h00_0000;
         wdPulse_q   <= 1'b0;
      end else begin
         wdOscPrev_q <= wdOscClk;
         wdCnt_q     <= wdCnt_d;
         wdPulse_q   <= wdPulse_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // reference enable and outputs

   logic refEnable_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         refEnable_q <= 1'b0;
      end else begin
         refEnable_q <= bodEnabled | compRefSelect | adcEnable;
      end
   end

   assign prdata    = prdata_q;
   assign pready    = pready_q;
   assign pslverr   = pslverr_q;
   assign coreReset = coreReset_q;
   assign refEnable = refEnable_q;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence ceOpened;
      $rose(watchdog_change_enable_q) && !ctlWr;
   endsequence
   sequence ceQuiet;
      (!ctlWr && !coreReset_q)[*3];
   endsequence

   pin_holds_a:    assert property (!resetPinN |=> coreReset_q)
      else $error("pin low did not hold reset");
   delay_release_a: assert property ($fell(coreReset_q) |->
      $past(dlyCnt_q) >= startupDelayCycles && $past(state_q) == RSW_ST_DELAY)
      else $error("reset released before start-up delay");
   bod_reset_a:    assert property (bodHit |=> coreReset_q && flags_q[`RSW_FLAG_BOR])
      else $error("brown-out did not reset");
   bod_disable_a:  assert property ({fuses.brownoutLevelFuse1, fuses.brownoutLevelFuse0}
      == `RSW_BOD_OFF && supplyLow && resetPinN && !wdPulse_q && !debugResetReg
      && state_q == RSW_ST_RUN |=> !coreReset_q)
      else $error("disabled brown-out reset the core");
   wd_pulse_a:     assert property (wdPulse_q |=> !wdPulse_q && coreReset_q
      && state_q == RSW_ST_HOLD)
      else $error("watchdog pulse not one cycle");
   ce_window_a:    assert property (ceOpened ##1 ceQuiet |=> !watchdog_change_enable_q)
      else $error("change-enable not cleared after four cycles");
   lock_enable_a:  assert property (lock && !coreReset_q |-> wdEn_q && ctlRead.watchdogEnableBit)
      else $error("locked watchdog not enabled");
   protect_dis_a:  assert property (ctlWr && !watchdog_change_enable_q && wdEn_q && !coreReset_q |=> wdEn_q)
      else $error("watchdog disabled without change-enable");
   prescale_hold_a: assert property (ctlWr && !watchdog_change_enable_q && !coreReset_q |=> $stable(wdPs_q))
      else $error("prescale changed outside window");
   wd_restart_a:   assert property (wdRestart |=> wdCnt_q == 22'h00_0000)
      else $error("restart did not clear watchdog");
   ref_enable_a:   assert property (compRefSelect |=> refEnable_q)
      else $error("reference not enabled");

endmodule

// *** verif/rsw_far_side.sv ***
// far-side model: reset pin, supply comparator, debug scan register, watchdog oscillator
// assumes the bench calls its tasks right after a rising clk edge
`timescale 1ns/100ps

module rsw_far_side (
   input  wire logic clk,           // system clock
   output logic      resetPinN,     // external reset pin, low active
   output logic      supplyLow,     // supply comparator, high = supply low
   output logic      debugResetReg, // debug scan reset register bit
   output logic      wdOscClk       // watchdog oscillator level
);
   logic oscPhase_q;

   initial begin
      resetPinN = 1'b1;
      supplyLow = 1'b0;
      debugResetReg = 1'b0;
      wdOscClk = 1'b0;
      oscPhase_q = 1'b0;
   end

   ////////////////////////////////////////////////////////////
   // a quarter of clk: slower than clk/2 so no oscillator edge is lost
   always @(posedge clk) begin
      oscPhase_q <= ~oscPhase_q;
      if (oscPhase_q) begin
         wdOscClk <= ~wdOscClk;
      end
   end

   // each level lasts at least one whole clk, above the minimum pulse width
   task automatic set_pin(input logic v);
      resetPinN <= v;
   endtask

   task automatic set_supply(input logic v);
      supplyLow <= v;
   endtask

   task automatic set_debug(input logic v);
      debugResetReg <= v;
   endtask
endmodule

// *** verif/tb_top.sv ***
// self-checking bench for the reset-source and watchdog block
// assumes the far-side model drives pin, supply, debug and oscillator
`timescale 1ns/100ps
`include "rsw_defines.svh"

module tb_top;
   import rsw_pkg::*;
   typedef struct {
      logic        w;
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] r;
      logic        e;
   } rsw_row_t;
   localparam int WDB = 4;
   localparam int DLY = 3;
   localparam int WDPER = (1 << WDB) * 4; // oscillator is a quarter of clk
   localparam logic [31:0] ONE = 32'h0000_0001;
   localparam logic [11:0] STA = `RSW_OFF_STATUS;
   localparam logic [11:0] WDC = `RSW_OFF_WDCTL;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic         wdRestart;
   logic         compRefSelect;
   logic         adcEnable;
   logic [15:0]  dly;
   rsw_fuse_t    fuses;
   rsw_apb_req_t apbReq = '0;
   logic         resetPinN, supplyLow, debugResetReg, wdOscClk;
   logic [31:0]  prdata, rd;
   logic         pready, pslverr, coreReset, refEnable, er;
   int           errTotal = 0;
   int           checksDone = 0;
   int           n;
   rsw_row_t     rows [8] = '{
      '{1'b0, STA, `RSW_ZERO32, ONE, 1'b0},
      '{1'b1, STA, `RSW_ZERO32, `RSW_ZERO32, 1'b0},
      '{1'b0, STA, `RSW_ZERO32, `RSW_ZERO32, 1'b0},
      '{1'b1, WDC, 32'h0000_00e7, `RSW_ZERO32, 1'b0},
      '{1'b0, WDC, `RSW_ZERO32, `RSW_ZERO32, 1'b0},
      '{1'b0, 12'h008, `RSW_ZERO32, `RSW_ZERO32, 1'b1},
      '{1'b1, 12'h00c, 32'h0000_00ff, `RSW_ZERO32, 1'b1},
      '{1'b0, STA, `RSW_ZERO32, `RSW_ZERO32, 1'b0}};

   always #50 clk = ~clk;

   rsw_far_side u_far (.clk(clk), .resetPinN(resetPinN), .supplyLow(supplyLow),
      .debugResetReg(debugResetReg), .wdOscClk(wdOscClk));

   rsw_top #(.WD_BASE_LOG2(WDB)) dut (.clk(clk), .rst(rst), .resetPinN(resetPinN),
      .supplyLow(supplyLow), .debugResetReg(debugResetReg), .fuses(fuses),
      .startupDelayCycles(dly), .compRefSelect(compRefSelect),
      .adcEnable(adcEnable), .wdOscClk(wdOscClk), .wdRestart(wdRestart),
      .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .coreReset(coreReset), .refEnable(refEnable));

   ////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (errTotal == 0 && checksDone > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         errTotal++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // every task is entered and left right after a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      apbReq <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) errTotal++;
      rd = prdata;
      er = pslverr;
   endtask

   task automatic idle();
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d);
      apb(w, a, d);
      idle();
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      rw(1'b0, a, `RSW_ZERO32);
      chk("prdata", exp, rd);
   endtask

   task automatic wait_run();
      int k;
      k = 0;
      while (coreReset !== 1'b0 && k < 300) begin
         @(posedge clk);
         k++;
      end
      chk("coreReset", `RSW_ZERO32, 32'(coreReset));
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      int i;
      wdRestart <= 1'b0;
      compRefSelect <= 1'b0;
      adcEnable <= 1'b0;
      fuses <= 3'h6;
      dly <= 16'(DLY);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      wait_run();
      for (i = 0; i < 8; i++) begin
         rw(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk("prdata", rows[i].r, rd);
         chk("pslverr", 32'(rows[i].e), 32'(er));
      end
      u_far.set_pin(1'b0);
      #1 chk("coreReset", ONE, 32'(coreReset));
      @(posedge clk);
      u_far.set_pin(1'b1);
      repeat (DLY + 2) @(posedge clk);
      chk("coreReset", ONE, 32'(coreReset));
      @(posedge clk);
      chk("coreReset", `RSW_ZERO32, 32'(coreReset));
      rd_chk(STA, 32'h0000_0002);
      rw(1'b1, STA, `RSW_ZERO32);
      for (i = 0; i < 4; i++) begin
         {fuses.brownoutLevelFuse1, fuses.brownoutLevelFuse0} <= 2'(i);
         @(posedge clk);
         u_far.set_supply(1'b1);
         #1 chk("coreReset", 32'(i != 3), 32'(coreReset));
         @(posedge clk);
         u_far.set_supply(1'b0);
         wait_run();
         rd_chk(STA, (i != 3) ? 32'h0000_0004 : `RSW_ZERO32);
         rw(1'b1, STA, `RSW_ZERO32);
      end
      for (i = 0; i < 8; i++) begin
         {fuses.brownoutLevelFuse1, fuses.brownoutLevelFuse0} <= i[2] ? 2'b01 : `RSW_BOD_OFF;
         compRefSelect <= i[1];
         adcEnable <= i[0];
         repeat (2) @(posedge clk);
         chk("refEnable", 32'(i != 0), 32'(refEnable));
      end
      u_far.set_debug(1'b1);
      repeat (2) @(posedge clk);
      chk("coreReset", ONE, 32'(coreReset));
      u_far.set_debug(1'b0);
      wait_run();
      rd_chk(STA, 32'h0000_0010);
      rw(1'b1, STA, `RSW_ZERO32);
      rw(1'b1, WDC, 32'h0000_0008);
      repeat (4) begin
         wdRestart <= 1'b1;
         @(posedge clk);
         wdRestart <= 1'b0;
         repeat (WDPER - 16) @(posedge clk);
      end
      rd_chk(STA, `RSW_ZERO32);
      wdRestart <= 1'b1;
      @(posedge clk);
      wdRestart <= 1'b0;
      n = 0;
      while (coreReset !== 1'b1 && n < 2 * WDPER) begin
         @(posedge clk);
         n++;
      end
      chk("wdPeriod", ONE, 32'(n >= WDPER - 4 && n <= WDPER + 6));
      n = 0;
      while (coreReset !== 1'b0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk("wdResetLen", 32'(DLY + 2), 32'(n));
      rd_chk(STA, 32'h0000_0008);
      rd_chk(WDC, `RSW_ZERO32);
      rw(1'b1, STA, `RSW_ZERO32);
      rw(1'b1, WDC, 32'h0000_0008);
      apb(1'b1, WDC, 32'h0000_0018);
      apb(1'b0, WDC, `RSW_ZERO32);
      idle();
      chk("prdata", 32'h0000_0018, rd);
      rd_chk(WDC, 32'h0000_0008);
      rw(1'b1, WDC, 32'h0000_0003);
      rd_chk(WDC, 32'h0000_0008);
      apb(1'b1, WDC, 32'h0000_0018);
      apb(1'b1, WDC, 32'h0000_0002);
      idle();
      rd_chk(WDC, 32'h0000_0002);
      fuses.watchdogLockFuse <= 1'b1;
      wdRestart <= 1'b1;
      dly <= 16'(DLY + 2);
      u_far.set_pin(1'b0);
      @(posedge clk);
      u_far.set_pin(1'b1);
      repeat (DLY + 4) @(posedge clk);
      chk("coreReset", ONE, 32'(coreReset));
      @(posedge clk);
      chk("coreReset", `RSW_ZERO32, 32'(coreReset));
      rd_chk(WDC, 32'h0000_0008);
      rw(1'b1, WDC, `RSW_ZERO32);
      rd_chk(WDC, 32'h0000_0008);
      apb(1'b1, WDC, 32'h0000_0018);
      apb(1'b1, WDC, 32'h0000_0001);
      idle();
      rd_chk(WDC, 32'h0000_0009);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wait_run();
      rd_chk(STA, ONE);
      u_far.set_pin(1'b0);
      @(posedge clk);
      u_far.set_pin(1'b1);
      wait_run();
      rd_chk(STA, 32'h0000_0003);
      end_of_test();
   end

   // the sequence needs well under a thousand cycles
   initial begin
      #(3000 * 100);
      errTotal++;
      end_of_test();
   end
endmodule
